// ---- inc/cidl_defines.svh ----
// Purpose: constants of the configuration front end (sync word, width pattern, register map, timing)
// Assumes: 25 MHz system clock
// Notes:   offsets and bit positions are shared by design and bench
`ifndef CIDL_DEFINES_SVH
`define CIDL_DEFINES_SVH

// ----------------------------------------------------------------------
// stream patterns
// ----------------------------------------------------------------------
`define CIDL_SYNC_WORD   32'haa995566
`define CIDL_SYNC_SWAP   32'h5599aa66
`define CIDL_BWD_FIRST   8'hbb
`define CIDL_BWD_X8      8'h11
`define CIDL_BWD_X16     16'h1122
`define CIDL_BWD_X32     32'h11220044

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define CIDL_ADDR_STATUS 8'h00
`define CIDL_ADDR_CTRL   8'h04
`define CIDL_ST_INITDONE 0
`define CIDL_ST_MODE_LO  1
`define CIDL_ST_FS_LO    4
`define CIDL_ST_WID_LO   7
`define CIDL_ST_CRCERR   9
`define CIDL_ST_RCMD_LO  16
`define CIDL_CT_RBCRC    0
`define CIDL_CT_ICAPEN   1
`define CIDL_CT_ICAPW_LO 2
`define CIDL_CT_REINIT   4
`define CIDL_CTRL_RESET  32'h00000000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CIDL_CLK_NS      40
`define CIDL_TPL_NS      2000
`define CIDL_TPL_CYC     ((`CIDL_TPL_NS + `CIDL_CLK_NS - 1) / `CIDL_CLK_NS)
`define CIDL_CLEAR_CYC   64
`define CIDL_CONFIG_CLOCK_HALF   4

`endif

// ---- inc/cidl_pkg.sv ----
// Purpose: types of the configuration front end
// Assumes: nothing
// Notes:   mode codes are pin encodings of this block
package cidl_pkg;

   // ----------------------------------------------------------------------
   // enumerations
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      M_MSERIAL = 3'h0, M_SPI = 3'h1, M_FLASH_ASC = 3'h2, M_FLASH_DESC = 3'h3,
      M_MPAR = 3'h4, M_JTAG = 3'h5, M_SPAR = 3'h6, M_SSERIAL = 3'h7
   } cidl_mode_t;

   typedef enum logic [1:0] {W_X1 = 2'h0, W_X8 = 2'h1, W_X16 = 2'h2, W_X32 = 2'h3} cidl_width_t;

   // gray along clear, drive, hold, hunt, synced
   typedef enum logic [2:0] {
      S_CLEAR = 3'h0, S_DRIVE = 3'h1, S_HOLD = 3'h3, S_HUNT = 3'h2, S_SYNCED = 3'h6
   } cidl_fsm_t;

   // ----------------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic        init;
      logic        config_clock;
      logic        abort;
      logic [2:0]  mode;
      logic [2:0]  fs;
      logic [7:0]  rcmd;
      logic [31:0] data;
   } cidl_pins_t;

   typedef struct packed {
      logic        rb_crc_en;
      logic        internal_config_port_en;
      cidl_width_t internal_config_port_width;
   } cidl_ctrl_t;

   typedef struct packed {
      logic [31:0] sr;
      logic [5:0]  bits;
      logic [31:0] acc;
      logic        synced;
      logic [31:0] word;
      logic        valid;
   } cidl_det_t;

   function automatic logic is_parallel(input logic [2:0] m);
      return m == M_FLASH_ASC || m == M_FLASH_DESC || m == M_MPAR || m == M_SPAR;
   endfunction

   function automatic logic is_master(input logic [2:0] m);
      return m == M_MSERIAL || m == M_SPI || m == M_FLASH_ASC || m == M_FLASH_DESC || m == M_MPAR;
   endfunction

endpackage

// ---- hdl/cidl_sync_det.sv ----
// Purpose: sync word hunt and 32-bit word alignment of the configuration stream
// Assumes: beat is a one-cycle pulse per rising config clock edge; width settled before beats
// Notes:   parallel data arrives bit-reversed within each byte
`timescale 1ns/100ps
`default_nettype none
`include "cidl_defines.svh"

module cidl_sync_det
   import cidl_pkg::*;
#(
   parameter int DW = 32
) (
   input  wire logic        clk_sys,    // system clock
   input  wire logic        rst,        // async reset, high
   input  wire logic        clr,        // level: back to hunting
   input  wire logic        beat,       // data sample strobe
   input  wire cidl_width_t width,      // detected bus width
   input  wire logic [DW-1:0] data,     // sampled data pins
   output logic             synced,     // alignment achieved
   output logic [31:0]      word,       // aligned word, bitstream order
   output logic             word_valid  // one-cycle word strobe
);

   if (DW != 32) begin : g_bad_dw
      $error("cidl_sync_det supports only a 32-bit data bus");
   end

   cidl_det_t q;
   cidl_det_t next_q;
   logic [31:0] sr_in;
   logic [5:0]  step;

   // undo the per-byte bit reversal of parallel buses
   function automatic logic [31:0] byte_rev(input logic [31:0] v);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 32; i++) begin
         r[(i / 8) * 8 + 7 - (i % 8)] = v[i];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.valid = 1'b0;
      case (width)
         W_X1:    begin sr_in = {q.sr[30:0], data[0]};   step = 6'h01; end
         W_X8:    begin sr_in = {q.sr[23:0], data[7:0]}; step = 6'h08; end
         W_X16:   begin sr_in = {q.sr[15:0], data[15:0]}; step = 6'h10; end
         default: begin sr_in = data[31:0];              step = 6'h20; end
      endcase
      if (clr) begin
         next_q = '0;
      end else if (beat && !q.synced) begin
         next_q.sr = sr_in;
         if (sr_in == ((width == W_X1) ? `CIDL_SYNC_WORD : `CIDL_SYNC_SWAP)) begin
            next_q.synced = 1'b1;
            next_q.bits = 6'h00;
         end
      end else if (beat) begin
         next_q.sr = sr_in;
         if (q.bits + step >= 6'h20) begin
            next_q.bits = 6'h00;
            next_q.word = (width == W_X1) ? sr_in : byte_rev(sr_in);
            next_q.valid = 1'b1;
         end else begin
            next_q.bits = q.bits + step;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign synced = q.synced;
   assign word = q.word;
   assign word_valid = q.valid;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   chk_hunt_discard: assert property (@(posedge clk_sys) disable iff (rst)
      !q.synced |=> !q.valid) else $error("word emitted before sync");
   chk_serial_match: assert property (@(posedge clk_sys) disable iff (rst)
      (beat && !clr && !q.synced && width == W_X1 && {q.sr[30:0], data[0]} == `CIDL_SYNC_WORD)
      |=> q.synced && q.bits == 6'h00) else $error("serial sync word missed");

endmodule
`default_nettype wire

// ---- hdl/cidl_top.sv ----
// Purpose: configuration front end: init delay, init pin, pin status, width detect, sync
// Assumes: one 25 MHz clock; pins and config clock pass two flops first
// Notes:   program pin low resets everything at once
//
// Contract
// - external init low holds start only during initialization, not after release
// - program pin is an async chip reset; low keeps configuration deferred
// - between init release and mode sampling the init pin is only an input
// - after sampling init drives low on crc or enabled readback crc error
// - status flag shows whether own init drive is released
// - mode status field returns live mode pins at read time
// - flash select field holds pins captured when init rises
// - parallel modes detect bus width before sync hunting
// - serial, spi and jtag modes ignore the width pattern
// - on sync word the stream is aligned to 32-bit words
// - data before sync is discarded except width pattern
// - sync flag visible only on parallel port during abort
// - width field: 00 x1, 01 x8, 10 x16, 11 x32
// - init rise samples mode, flash select, read command; masters drive clock
// - device holds init low, releases after delay, waits on external low
// - configuration memory cleared twice after program release
// - parallel data bit-reversed per byte; sync matched in swapped form
`timescale 1ns/100ps
`default_nettype none
`include "cidl_defines.svh"

module cidl_top
   import cidl_pkg::*;
#(
   parameter int TPL_CYC   = `CIDL_TPL_CYC,
   parameter int CLEAR_CYC = `CIDL_CLEAR_CYC,
   parameter int CONFIG_CLOCK_HALF = `CIDL_CONFIG_CLOCK_HALF
) (
   input  wire logic        clk_sys,            // system clock
   input  wire logic        rst,                // async reset, high
   input  wire logic        program_n,          // program pin, low resets
   input  wire logic        init_i,             // init pin level
   output logic             init_o,             // init pin drive value
   output logic             init_oe,            // init pin pull-down enable
   input  wire logic        config_clock_i,             // config clock pin level
   output logic             config_clock_o,             // config clock drive
   output logic             config_clock_oe,            // config clock enable
   input  wire logic [2:0]  mode_pins,          // mode straps
   input  wire logic [2:0]  flash_select_pins,  // flash select straps
   input  wire logic [7:0]  read_command_pins,  // read command straps
   input  wire logic [31:0] data_pins,          // config data
   input  wire logic        abort_i,            // abort sequence active
   output logic             sync_achieved_flag, // sync state during abort
   input  wire logic        crc_error,          // config crc error pulse
   input  wire logic        rb_crc_error,       // readback crc error pulse
   input  wire logic        cfg_done,           // configuration complete
   input  wire logic [7:0]  reg_addr,           // register address
   input  wire logic [31:0] reg_wdata,          // register write data
   input  wire logic        reg_wr,             // write strobe
   input  wire logic        reg_rd,             // read strobe
   output logic [31:0]      reg_rdata,          // read data, next cycle
   output logic [31:0]      cfg_word,           // aligned config word
   output logic             cfg_word_valid      // word strobe
);

   if (TPL_CYC < 1 || TPL_CYC > 4095 || CLEAR_CYC < 1 || CLEAR_CYC > 4095 ||
       CONFIG_CLOCK_HALF < 1 || CONFIG_CLOCK_HALF > 15) begin : g_bad_par
      $error("cidl_top count parameter out of range");
   end

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   typedef struct packed {
      cidl_pins_t  s1;
      cidl_pins_t  s2;
      cidl_fsm_t   fsm;
      logic [11:0] cnt;
      logic        pass;
      logic [2:0]  mode_cap;
      logic [2:0]  fs_cap;
      logic [7:0]  rcmd_cap;
      cidl_width_t width;
      logic        bwd_seen;
      logic        width_done;
      logic        crc_err;
      logic        init_oe;
      logic        config_clock_prev;
      logic [3:0]  div;
      logic        config_clock_o;
      logic        config_clock_oe;
      logic        beat;
      logic        reinit;
      logic        sync_out;
      cidl_ctrl_t  ctrl;
      logic [31:0] rdata;
   } cidl_top_t;

   cidl_top_t   q;
   cidl_top_t   next_q;
   logic        rst_chip;
   logic        synced;
   cidl_width_t width_rep;
   cidl_pins_t  pins;
   logic        crc_evt;

   // program pin resets the whole chip
   assign rst_chip = rst | ~program_n;

   assign pins = '{init: init_i, config_clock: config_clock_i, abort: abort_i, mode: mode_pins,
                   fs: flash_select_pins, rcmd: read_command_pins, data: data_pins};

   assign width_rep = (q.ctrl.internal_config_port_en && cfg_done) ? q.ctrl.internal_config_port_width : q.width;

   // crc events count only after mode sampling
   assign crc_evt = (q.fsm == S_HUNT || q.fsm == S_SYNCED) &&
                    (crc_error || (rb_crc_error && q.ctrl.rb_crc_en));

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb begin
      next_q = q;
      // pins pass two flops; only s2 is read by logic
      next_q.s1 = pins;
      next_q.s2 = q.s1;
      next_q.beat = 1'b0;
      next_q.reinit = 1'b0;
      next_q.rdata = 32'h00000000;

      // sequencer
      case (q.fsm)
         S_CLEAR: begin
            next_q.init_oe = 1'b1;
            if (q.cnt == 12'(CLEAR_CYC - 1)) begin
               next_q.cnt = 12'h000;
               next_q.pass = 1'b1;
               if (q.pass) begin
                  next_q.fsm = S_DRIVE;
               end
            end else begin
               next_q.cnt = q.cnt + 12'h001;
            end
         end
         S_DRIVE: begin
            if (q.cnt == 12'(TPL_CYC - 1)) begin
               next_q.cnt = 12'h000;
               next_q.init_oe = 1'b0;
               next_q.fsm = S_HOLD;
            end else begin
               next_q.cnt = q.cnt + 12'h001;
            end
         end
         S_HOLD: begin
            next_q.init_oe = 1'b0;
            if (q.s2.init) begin
               next_q.mode_cap = q.s2.mode;
               next_q.fs_cap = q.s2.fs;
               next_q.rcmd_cap = q.s2.rcmd;
               next_q.width = W_X1;
               next_q.bwd_seen = 1'b0;
               next_q.width_done = !is_parallel(q.s2.mode);
               next_q.fsm = S_HUNT;
            end
         end
         S_HUNT: begin
            if (synced) begin
               next_q.fsm = S_SYNCED;
            end
         end
         S_SYNCED: begin
            next_q.fsm = S_SYNCED;
         end
         default: begin
            next_q.fsm = S_CLEAR;
         end
      endcase

      // config clock: master divider, slave edge detect
      next_q.config_clock_prev = q.s2.config_clock;
      if (q.fsm == S_HUNT || q.fsm == S_SYNCED) begin
         next_q.config_clock_oe = is_master(q.mode_cap);
         if (is_master(q.mode_cap)) begin
            if (q.div == 4'(CONFIG_CLOCK_HALF - 1)) begin
               next_q.div = 4'h0;
               next_q.config_clock_o = !q.config_clock_o;
               next_q.beat = !q.config_clock_o;
            end else begin
               next_q.div = q.div + 4'h1;
            end
         end else begin
            next_q.beat = q.s2.config_clock && !q.config_clock_prev;
         end
      end else begin
         next_q.config_clock_oe = 1'b0;
         next_q.config_clock_o = 1'b0;
         next_q.div = 4'h0;
      end

      if (q.beat && q.fsm == S_HUNT && !q.width_done) begin
         if (!q.bwd_seen) begin
            next_q.bwd_seen = (q.s2.data[7:0] == `CIDL_BWD_FIRST);
         end else begin
            next_q.width_done = 1'b1;
            if (q.s2.data == `CIDL_BWD_X32) begin
               next_q.width = W_X32;
            end else if (q.s2.data[15:0] == `CIDL_BWD_X16) begin
               next_q.width = W_X16;
            end else if (q.s2.data[7:0] == `CIDL_BWD_X8) begin
               next_q.width = W_X8;
            end else begin
               next_q.width_done = 1'b0;
               next_q.bwd_seen = 1'b0;
            end
         end
      end

      // crc errors drive init low after sampling
      if (crc_evt) begin
         next_q.crc_err = 1'b1;
      end
      if (q.fsm == S_HUNT || q.fsm == S_SYNCED) begin
         next_q.init_oe = next_q.crc_err;
      end

      // sync flag only on parallel port in abort
      next_q.sync_out = synced && q.s2.abort && (q.mode_cap == M_MPAR || q.mode_cap == M_SPAR);

      // register writes
      if (reg_wr && reg_addr == `CIDL_ADDR_CTRL) begin
         next_q.ctrl.rb_crc_en = reg_wdata[`CIDL_CT_RBCRC];
         next_q.ctrl.internal_config_port_en = reg_wdata[`CIDL_CT_ICAPEN];
         next_q.ctrl.internal_config_port_width = cidl_width_t'(reg_wdata[`CIDL_CT_ICAPW_LO +: 2]);
         next_q.reinit = reg_wdata[`CIDL_CT_REINIT];
      end

      // register reads, data valid the next cycle only
      if (reg_rd) begin
         case (reg_addr)
            `CIDL_ADDR_STATUS: begin
               next_q.rdata[`CIDL_ST_INITDONE] = !q.init_oe && q.fsm != S_CLEAR && q.fsm != S_DRIVE;
               next_q.rdata[`CIDL_ST_MODE_LO +: 3] = q.s2.mode;
               next_q.rdata[`CIDL_ST_FS_LO +: 3] = q.fs_cap;
               next_q.rdata[`CIDL_ST_WID_LO +: 2] = width_rep;
               next_q.rdata[`CIDL_ST_CRCERR] = q.crc_err;
               next_q.rdata[`CIDL_ST_RCMD_LO +: 8] = q.rcmd_cap;
            end
            `CIDL_ADDR_CTRL: begin
               next_q.rdata[`CIDL_CT_RBCRC] = q.ctrl.rb_crc_en;
               next_q.rdata[`CIDL_CT_ICAPEN] = q.ctrl.internal_config_port_en;
               next_q.rdata[`CIDL_CT_ICAPW_LO +: 2] = q.ctrl.internal_config_port_width;
            end
            default: begin
               next_q.rdata = 32'h00000000;
            end
         endcase
      end

      if (q.reinit) begin
         next_q.fsm = S_CLEAR;
         next_q.cnt = 12'h000;
         next_q.pass = 1'b0;
         next_q.width = W_X1;
         next_q.width_done = 1'b0;
         next_q.bwd_seen = 1'b0;
         // an error in the reinit cycle itself still wins
         next_q.crc_err = crc_evt;
         next_q.init_oe = 1'b1;
         next_q.config_clock_oe = 1'b0;
         next_q.sync_out = 1'b0;
      end
   end

   // registered state; program low holds clear state
   always_ff @(posedge clk_sys or posedge rst_chip) begin
      if (rst_chip) begin
         q <= '0;
         q.init_oe <= 1'b1;
         q.ctrl <= cidl_ctrl_t'(`CIDL_CTRL_RESET);
      end else begin
         q <= next_q;
      end
   end

   // ----------------------------------------------------------------------
   // aligner
   // ----------------------------------------------------------------------
   // alignment, swapped compare on parallel buses
   cidl_sync_det #(
      .DW (32)
   ) u_det (
      .clk_sys    (clk_sys),
      .rst        (rst_chip),
      .clr        (q.fsm != S_HUNT && q.fsm != S_SYNCED || q.reinit),
      .beat       (q.beat && q.width_done),
      .width      (q.width),
      .data       (q.s2.data),
      .synced     (synced),
      .word       (cfg_word),
      .word_valid (cfg_word_valid)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // open drain: value always low, enable decides
   assign init_o = q.config_clock_prev & 1'b0;
   assign init_oe = q.init_oe;
   assign config_clock_o = q.config_clock_o;
   assign config_clock_oe = q.config_clock_oe;
   assign sync_achieved_flag = q.sync_out;
   assign reg_rdata = q.rdata;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst_chip);

   chk_init_hold: assert property (
      q.fsm == S_HOLD && !q.s2.init && !q.reinit |=> q.fsm == S_HOLD) else $error("init low not honoured");
   chk_init_late: assert property (
      q.fsm == S_SYNCED && !q.s2.init && !q.reinit |=> q.fsm == S_SYNCED) else $error("late init low delayed");
   chk_prog_reset: assert property (@(posedge clk_sys) disable iff (rst)
      !program_n |-> q.fsm == S_CLEAR && q.init_oe) else $error("program low not resetting");
   chk_init_input: assert property (
      q.fsm == S_HOLD |-> !q.init_oe) else $error("init driven while input");
   chk_init_crc: assert property (
      (q.fsm == S_HUNT || q.fsm == S_SYNCED) && crc_error && !q.reinit |=> q.init_oe [*2])
      else $error("crc error not driven");
   chk_init_release: assert property (
      q.fsm == S_DRIVE && q.cnt == 12'(TPL_CYC - 1) && !q.reinit |=> q.fsm == S_HOLD && !q.init_oe)
      else $error("init release late");
   chk_mode_live: assert property (
      reg_rd && reg_addr == `CIDL_ADDR_STATUS |=> reg_rdata[`CIDL_ST_MODE_LO +: 3] == $past(q.s2.mode))
      else $error("mode status not live");
   chk_fs_capture: assert property (
      q.fsm == S_HOLD && q.s2.init && !q.reinit |=> q.fs_cap == $past(q.s2.fs) && q.fsm == S_HUNT)
      else $error("flash select not captured");
   chk_width_serial: assert property (
      q.fsm == S_HUNT && !is_parallel(q.mode_cap) |-> q.width == W_X1 && q.width_done)
      else $error("serial mode detected width");
   chk_clear_twice: assert property (
      $rose(q.fsm == S_DRIVE) |-> $past(q.pass)) else $error("memory cleared once");
   chk_reinit_clear: assert property (
      q.reinit |=> q.width == W_X1 && !q.width_done ##1 !synced) else $error("reinit left state");

   cov_synced: cover property ($rose(synced));
   cov_crc_drive: cover property (q.fsm == S_SYNCED && $rose(q.init_oe));
   cov_x32: cover property ($rose(q.width == W_X32));

endmodule
`default_nettype wire

// ---- dv/cidl_src_model.sv ----
// Purpose: slave serial configuration source on the far side
// Assumes: config clock of 320 ns, only running inside a frame
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/100ps
`default_nettype none
module cidl_src_model (
   output logic config_clock, // config clock to the device
   output logic dq    // serial data bit
);
   initial begin
      config_clock = 1'b0;
      dq = 1'b0;
   end
   // bits msb first, clock idle low between frames
   task automatic send(input logic [31:0] w, input int n);
      #5; // step off the system clock edges
      for (int i = n - 1; i >= 0; i--) begin
         dq = w[i];
         #160 config_clock = 1'b1;
         #160 config_clock = 1'b0;
      end
      dq = ~dq; // no stale level once released
   endtask
endmodule
`default_nettype wire

// ---- dv/cidl_top_test.sv ----
// Purpose: self-checking bench of the configuration front end
// Assumes: slave serial straps, small clear and delay counts
// Notes:   reads and words are checked from one queue of notes
`timescale 1ns/100ps
`default_nettype none
`include "cidl_defines.svh"
module cidl_top_test;
   import cidl_pkg::*;
   logic        clk_sys, rst, program_n, ext_hold, crc_error, reg_wr, reg_rd, rd_d, cfg_done;
   logic        init_oe, config_clock_oe, config_clock, dq, cfg_word_valid;
   logic [2:0]  mode_pins, fs_pins;
   logic [7:0]  reg_addr, rcmd;
   logic [31:0] reg_wdata, reg_rdata, cfg_word, hi_bits, w;
   logic [63:0] q[$];
   int          bad_count, total_checks, seed;
   // board pull-up, pin low if anyone pulls
   cidl_top #(.TPL_CYC(2), .CLEAR_CYC(2), .CONFIG_CLOCK_HALF(1)) DUT (.clk_sys(clk_sys), .rst(rst), .program_n(program_n),
      .init_i(~(init_oe | ext_hold)), .init_o(), .init_oe(init_oe), .config_clock_i(config_clock), .config_clock_o(), .config_clock_oe(config_clock_oe),
      .mode_pins(mode_pins), .flash_select_pins(fs_pins), .read_command_pins(rcmd), .data_pins({hi_bits[31:1], dq}),
      .abort_i(1'b0), .sync_achieved_flag(), .crc_error(crc_error), .rb_crc_error(1'b0), .cfg_done(cfg_done),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cfg_word(cfg_word), .cfg_word_valid(cfg_word_valid));
   cidl_src_model SRC (.config_clock(config_clock), .dq(dq));
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      q.push_back({m, e});
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   // bounded wait until every note is matched
   task automatic drain(input string nm);
      @(posedge clk_sys);
      for (int i = 0; i < 400 && q.size() > 0; i++) @(posedge clk_sys);
      if (q.size() > 0) begin
         bad_count++;
         stop_test();
      end else begin
         $display("done %s", nm);
      end
   endtask
   // monitor: oldest note against read data or word
   always @(posedge clk_sys) begin
      rd_d <= reg_rd;
      if (rd_d || cfg_word_valid) begin
         chk(rd_d ? "rdata" : "cfg_word", q[0][31:0], (rd_d ? reg_rdata : cfg_word) & q[0][63:32]);
         void'(q.pop_front());
      end
   end
   initial begin
      seed = 55132;
      {rst, program_n, ext_hold, crc_error, reg_wr, reg_rd, cfg_done} = 7'b1110000;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      mode_pins = M_SSERIAL;
      fs_pins = 3'h5;
      rcmd = 8'($random(seed));
      hi_bits = $random(seed);
      w = $random(seed);
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (40) @(posedge clk_sys);
      chk("init_oe", 32'h0, {31'h0, init_oe});
      SRC.send(`CIDL_SYNC_WORD, 32);
      @(posedge clk_sys);
      ext_hold <= 1'b0;
      repeat (6) @(posedge clk_sys);
      fs_pins <= 3'h2;
      mode_pins <= 3'h3;
      ext_hold <= 1'b1;
      // live mode pins need two synchroniser stages before the read edge
      @(posedge clk_sys);
      rd(`CIDL_ADDR_STATUS, 32'h00ff03ff, {8'h0, rcmd, 9'h0, 3'h5, 3'h3, 1'b1});
      drain("straps");
      q.push_back({32'hffffffff, w});
      SRC.send(32'h15, 5);
      SRC.send(`CIDL_SYNC_WORD, 32);
      SRC.send(w, 32);
      drain("sync");
      crc_error <= 1'b1;
      @(posedge clk_sys);
      crc_error <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("init_oe", 32'h1, {31'h0, init_oe});
      chk("config_clock_oe", 32'h0, {31'h0, config_clock_oe});
      rd(`CIDL_ADDR_STATUS, 32'h00000381, 32'h00000200);
      wr(`CIDL_ADDR_CTRL, 32'h0000000e);
      rd(`CIDL_ADDR_CTRL, 32'hffffffff, 32'h0000000e);
      cfg_done <= 1'b1;
      rd(`CIDL_ADDR_STATUS, 32'h00000180, 32'h00000180);
      cfg_done <= 1'b0;
      rd(8'h08, 32'hffffffff, 32'h0);
      wr(`CIDL_ADDR_CTRL, 32'h00000010);
      repeat (20) @(posedge clk_sys);
      rd(`CIDL_ADDR_STATUS, 32'h00000380, 32'h0);
      drain("registers");
      program_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk("init_oe", 32'h1, {31'h0, init_oe});
      program_n <= 1'b1;
      stop_test();
   end
endmodule
`default_nettype wire
